// ---- rtl/cmost_pkg.sv ----
// Package: map, fields and codes of the message object register block
package cmost_pkg;
    localparam int OBJ_COUNT = 15;
    localparam int IDX_W = 4;
    localparam int AXI_AW = 8;
    localparam logic [IDX_W-1:0] OBJ_NONE = 4'hF;
    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFF_PAGE = 8'h00;
    localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h04;
    localparam logic [AXI_AW-1:0] OFF_CTRL = 8'h08;
    localparam logic [AXI_AW-1:0] OFF_TAG1 = 8'h0C;
    localparam logic [AXI_AW-1:0] OFF_TAG2 = 8'h10;
    localparam logic [AXI_AW-1:0] OFF_TAG3 = 8'h14;
    localparam logic [AXI_AW-1:0] OFF_TAG4 = 8'h18;
    localparam logic [AXI_AW-1:0] OFF_ENABLE = 8'h1C;
    localparam logic [AXI_AW-1:0] OFF_DONE = 8'h20;
    // Status bit positions
    localparam int ST_LENGTH_WARNING_FLAG = 7;
    localparam int ST_TRANSMIT_DONE_FLAG = 6;
    localparam int ST_RECEIVE_DONE_FLAG = 5;
    localparam int ST_BIT_ERROR_FLAG = 4;
    localparam int ST_STUFF_ERROR_FLAG = 3;
    localparam int ST_CRC_ERROR_FLAG = 2;
    localparam int ST_FORM_ERROR_FLAG = 1;
    localparam int ST_ACK_ERROR_FLAG = 0;
    // Control/length fields
    localparam int CT_CFG_HI = 7;
    localparam int CT_CFG_LO = 6;
    localparam int CT_REPLY_VALID_BIT = 5;
    localparam int CT_IDE = 4;
    localparam int CT_DLC_HI = 3;
    localparam int PAGE_LO = 4;
    // Tag fields
    localparam int TG_RTR = 2;
    localparam int TG_RB1 = 1;
    localparam int TG_RB0 = 0;
    localparam int TG_STD_LO = 21;
    localparam int TG_EXT_LO = 3;
    // Reset values, limits, CRC polynomial and response codes
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] TAG_RST = 32'h00000000;
    localparam logic [3:0] PAGE_RST = 4'h0;
    localparam logic [3:0] DLC_MAX = 4'h8;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        CFG_OFF = 2'h0,
        CFG_TX = 2'h1,
        CFG_RX = 2'h2,
        CFG_FBRX = 2'h3
    } cmost_cfg_t;
endpackage

// ---- rtl/cmost_core.sv ----
// Message object status, control and identifier tag block
`timescale 1ns/1ps
module cmost_core
    import cmost_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic can_rx,
    input wire logic sample_stb,
    input wire logic frame_start_stb,
    input wire logic tx_active,
    input wire logic tx_bit,
    input wire logic in_arbitration,
    input wire logic in_error_ack,
    input wire logic stuff_check_en,
    input wire logic bit_is_stuff,
    input wire logic crc_calc_en,
    input wire logic crc_recv_en,
    input wire logic crc_check_stb,
    input wire logic fixed_form_en,
    input wire logic ack_slot,
    input wire logic tx_start_stb,
    input wire logic tx_abort_stb,
    input wire logic tx_eof_stb,
    input wire logic [OBJ_COUNT-1:0] rx_hit_vec,
    input wire logic rx_eof6_stb,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_rtr,
    input wire logic rx_rb0,
    input wire logic rx_rb1,
    input wire logic [3:0] rx_dlc,
    output logic tx_req,
    output logic [IDX_W-1:0] tx_obj_idx,
    output logic [28:0] tx_id,
    output logic tx_ide,
    output logic tx_rtr,
    output logic tx_rb0,
    output logic tx_rb1,
    output logic [3:0] tx_dlc
);
    ////////////////////////////////////////////////////////////////////////
    // Object storage
    logic [7:0] status_r [OBJ_COUNT];
    logic [7:0] status_nxt [OBJ_COUNT];
    logic [7:0] ctrl_r [OBJ_COUNT];
    logic [7:0] ctrl_nxt [OBJ_COUNT];
    logic [31:0] tag_r [OBJ_COUNT];
    logic [31:0] tag_nxt [OBJ_COUNT];
    logic [OBJ_COUNT-1:0] en_r;
    logic [OBJ_COUNT-1:0] en_nxt;
    logic [OBJ_COUNT-1:0] done_r;
    logic [OBJ_COUNT-1:0] done_nxt;
    logic [OBJ_COUNT-1:0] reply_r;
    logic [OBJ_COUNT-1:0] reply_nxt;
    logic [OBJ_COUNT-1:0] armed_w;
    logic [OBJ_COUNT-1:0] rx_cand_w;
    logic [3:0] page_r;

    ////////////////////////////////////////////////////////////////////////
    // Bus level synchroniser, recessive after reset
    logic rx_meta_r;
    logic rx_s2_r;
    logic rx_s3_r;
    logic rx_lvl_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_meta_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
            rx_lvl_r <= 1'b1;
        end else begin
            rx_meta_r <= can_rx;
            rx_s2_r <= rx_meta_r;
            rx_s3_r <= rx_s2_r;
            if (rx_s2_r == rx_s3_r) begin
                rx_lvl_r <= rx_s3_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic aw_held_r;
    logic w_held_r;
    logic [AXI_AW-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    wire wr_fire = aw_held_r & w_held_r & ~bvalid_r;
    wire lane0 = wstrb_r[0];
    wire obj_ok_w = page_r < 4'(OBJ_COUNT);
    wire wr_page = wr_fire & lane0 & (awaddr_r == OFF_PAGE);
    wire wr_stat = wr_fire & lane0 & (awaddr_r == OFF_STATUS);
    wire wr_ctrl = wr_fire & lane0 & (awaddr_r == OFF_CTRL);
    wire [3:0] wr_tag;
    assign wr_tag[0] = wr_fire & lane0 & (awaddr_r == OFF_TAG4);
    assign wr_tag[1] = wr_fire & lane0 & (awaddr_r == OFF_TAG3);
    assign wr_tag[2] = wr_fire & lane0 & (awaddr_r == OFF_TAG2);
    assign wr_tag[3] = wr_fire & lane0 & (awaddr_r == OFF_TAG1);
    wire wr_map = (awaddr_r <= OFF_TAG4) & (awaddr_r[1:0] == 2'h0);
    wire rd_fire = s_axi_arvalid & ~rvalid_r;
    wire [AXI_AW-1:0] ra = s_axi_araddr;
    wire rd_map = (ra <= OFF_DONE) & (ra[1:0] == 2'h0);
    wire [3:0] rpg = obj_ok_w ? page_r : 4'h0;
    wire [7:0] rd_obj_w = ~obj_ok_w ? 8'h00 :
        (ra == OFF_STATUS) ? status_r[rpg] :
        (ra == OFF_CTRL) ? ctrl_r[rpg] :
        (ra == OFF_TAG1) ? tag_r[rpg][31:24] :
        (ra == OFF_TAG2) ? tag_r[rpg][23:16] :
        (ra == OFF_TAG3) ? tag_r[rpg][15:8] :
        (ra == OFF_TAG4) ? tag_r[rpg][7:0] : 8'h00;
    wire [31:0] rd_data_w =
        (ra == OFF_PAGE) ? {24'h000000, page_r, 4'h0} :
        (ra == OFF_ENABLE) ? {17'h00000, en_r} :
        (ra == OFF_DONE) ? {17'h00000, done_r} :
        {24'h000000, rd_obj_w};
    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_map ? rd_data_w : 32'h00000000;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_r <= PAGE_RST;
        end else if (wr_page) begin
            page_r <= wdata_r[PAGE_LO+3:PAGE_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Object selection
    logic [IDX_W-1:0] tx_sel_w;
    logic [IDX_W-1:0] rx_sel_w;
    always_comb begin
        tx_sel_w = OBJ_NONE;
        rx_sel_w = OBJ_NONE;
        for (int i = OBJ_COUNT - 1; i >= 0; i--) begin
            if (armed_w[i]) begin
                tx_sel_w = 4'(i);
            end
            if (rx_hit_vec[i] && en_r[i] && ctrl_r[i][CT_CFG_HI]) begin
                rx_sel_w = 4'(i);
            end
        end
    end
    wire tx_any_w = |armed_w;
    wire rx_any_w = rx_sel_w != OBJ_NONE;
    logic [IDX_W-1:0] tx_obj_r;
    logic tx_busy_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_obj_r <= OBJ_NONE;
            tx_busy_r <= 1'b0;
        end else if (tx_start_stb && tx_any_w) begin
            tx_obj_r <= tx_sel_w;
            tx_busy_r <= 1'b1;
        end else if (tx_eof_stb || tx_abort_stb) begin
            tx_busy_r <= 1'b0;
        end
    end
    wire err_tx_w = tx_active & tx_busy_r;
    wire err_ok_w = err_tx_w | (~tx_active & rx_any_w);
    wire [IDX_W-1:0] cur_obj_w = tx_active ? tx_obj_r : rx_sel_w;

    ////////////////////////////////////////////////////////////////////////
    // Error detection on sampled bits
    wire rx_bit = rx_lvl_r;
    wire lost_arb_w = in_arbitration & tx_bit & ~rx_bit;
    wire bit_error_flag_ev = sample_stb & err_tx_w & (tx_bit != rx_bit)
        & ~lost_arb_w & ~in_error_ack;
    logic [2:0] run_r;
    logic last_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_r <= 3'h0;
            last_r <= 1'b1;
        end else if (!stuff_check_en) begin
            run_r <= 3'h0;
        end else if (sample_stb) begin
            last_r <= rx_bit;
            run_r <= (rx_bit == last_r && run_r != 3'h0 && run_r < STUFF_RUN)
                ? run_r + 3'h1 : 3'h1;
        end
    end
    wire stuff_error_flag_ev = sample_stb & stuff_check_en & err_ok_w
        & (run_r == STUFF_RUN) & (rx_bit == last_r);
    logic [14:0] crc_r;
    logic [14:0] crc_rx_r;
    wire data_bit_stb = sample_stb & ~bit_is_stuff;
    wire crc_fb = rx_bit ^ crc_r[14];
    always_ff @(posedge aclk) begin
        if (!aresetn || frame_start_stb) begin
            crc_r <= 15'h0000;
            crc_rx_r <= 15'h0000;
        end else if (data_bit_stb && crc_calc_en) begin
            crc_r <= {crc_r[13:0], 1'b0} ^ (crc_fb ? CRC_POLY : 15'h0000);
        end else if (data_bit_stb && crc_recv_en) begin
            crc_rx_r <= {crc_rx_r[13:0], rx_bit};
        end
    end
    wire crc_error_flag_ev = crc_check_stb & err_ok_w & (crc_r != crc_rx_r);
    wire form_error_flag_ev = sample_stb & fixed_form_en & err_ok_w & ~rx_bit;
    wire ack_error_flag_ev = sample_stb & ack_slot & err_tx_w & rx_bit;
    wire [7:0] err_set_w = {3'h0, bit_error_flag_ev, stuff_error_flag_ev, crc_error_flag_ev, form_error_flag_ev,
        ack_error_flag_ev};

    ////////////////////////////////////////////////////////////////////////
    // Per-object next state
    wire tx_done_w = tx_eof_stb & tx_busy_r;
    wire rx_done_w = rx_eof6_stb & rx_any_w;
    wire [31:0] rx_tag_w = rx_ide ? {rx_id, rx_rb1, rx_rtr, rx_rb0}
        : {rx_id[10:0], rx_id[28:11], rx_rb1, rx_rtr, rx_rb0};
    always_comb begin
        for (int i = 0; i < OBJ_COUNT; i++) begin
            logic pg;
            logic txd;
            logic rxd;
            logic auto_rep;
            pg = obj_ok_w && (page_r == 4'(i));
            txd = tx_done_w && (tx_obj_r == 4'(i));
            rxd = rx_done_w && (rx_sel_w == 4'(i));
            auto_rep = rxd && rx_rtr && ctrl_r[i][CT_REPLY_VALID_BIT]
                && (ctrl_r[i][CT_CFG_HI:CT_CFG_LO] == CFG_RX);
            status_nxt[i] = status_r[i];
            ctrl_nxt[i] = ctrl_r[i];
            tag_nxt[i] = tag_r[i];
            en_nxt[i] = en_r[i];
            done_nxt[i] = done_r[i];
            reply_nxt[i] = reply_r[i];
            if (wr_stat && pg) begin
                status_nxt[i] = status_r[i] & wdata_r[7:0];
            end
            if (err_ok_w && cur_obj_w == 4'(i)) begin
                status_nxt[i] = status_nxt[i] | err_set_w;
            end
            if (txd) begin
                status_nxt[i][ST_TRANSMIT_DONE_FLAG] = 1'b1;
                en_nxt[i] = 1'b0;
                reply_nxt[i] = 1'b0;
            end
            if (rxd) begin
                status_nxt[i][ST_RECEIVE_DONE_FLAG] = 1'b1;
                en_nxt[i] = auto_rep;
                reply_nxt[i] = auto_rep;
                done_nxt[i] = ctrl_r[i][CT_CFG_HI:CT_CFG_LO] == CFG_FBRX;
                if (rx_dlc != ctrl_r[i][CT_DLC_HI:0]) begin
                    status_nxt[i][ST_LENGTH_WARNING_FLAG] = 1'b1;
                end
                ctrl_nxt[i][CT_DLC_HI:0] = rx_dlc;
                ctrl_nxt[i][CT_IDE] = rx_ide;
                tag_nxt[i] = rx_tag_w;
                tag_nxt[i][TG_RTR] = rx_rtr & ~auto_rep;
            end
            if (wr_ctrl && pg) begin
                ctrl_nxt[i] = wdata_r[7:0];
                en_nxt[i] = 1'b1;
                done_nxt[i] = 1'b0;
                reply_nxt[i] = 1'b0;
            end
            for (int b = 0; b < 4; b++) begin
                if (wr_tag[b] && pg) begin
                    tag_nxt[i][b*8 +: 8] = wdata_r[7:0];
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < OBJ_COUNT; i++) begin
                status_r[i] <= STATUS_RST;
                ctrl_r[i] <= CTRL_RST;
                tag_r[i] <= TAG_RST;
            end
            en_r <= '0;
            done_r <= '0;
            reply_r <= '0;
        end else begin
            status_r <= status_nxt;
            ctrl_r <= ctrl_nxt;
            tag_r <= tag_nxt;
            en_r <= en_nxt;
            done_r <= done_nxt;
            reply_r <= reply_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit offer to the frame engine
    for (genvar i = 0; i < OBJ_COUNT; i++) begin : g_arm
        assign armed_w[i] = en_r[i] & ~(tx_busy_r & tx_obj_r == 4'(i))
            & ((ctrl_r[i][CT_CFG_HI:CT_CFG_LO] == CFG_TX) | reply_r[i]);
        assign rx_cand_w[i] = rx_hit_vec[i] & en_r[i] & ctrl_r[i][CT_CFG_HI];
    end
    wire [3:0] ts = tx_any_w ? tx_sel_w : 4'h0;
    wire [31:0] ttag = tag_r[ts];
    wire tide = ctrl_r[ts][CT_IDE];
    wire [3:0] tdlc = ctrl_r[ts][CT_DLC_HI:0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_req <= 1'b0;
            tx_obj_idx <= OBJ_NONE;
            tx_id <= 29'h00000000;
            tx_ide <= 1'b0;
            tx_rtr <= 1'b0;
            tx_rb0 <= 1'b0;
            tx_rb1 <= 1'b0;
            tx_dlc <= 4'h0;
        end else begin
            tx_req <= tx_any_w;
            tx_obj_idx <= tx_sel_w;
            tx_id <= tide ? ttag[31:TG_EXT_LO]
                : {18'h00000, ttag[31:TG_STD_LO]};
            tx_ide <= tide;
            tx_rtr <= ttag[TG_RTR];
            tx_rb0 <= ttag[TG_RB0];
            tx_rb1 <= tide & ttag[TG_RB1];
            tx_dlc <= (tdlc > DLC_MAX) ? DLC_MAX : tdlc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rx_done;
        rx_done_w && !wr_ctrl;
    endsequence
    sequence s_tx_done;
        tx_done_w && !wr_ctrl;
    endsequence
    a_dlc_warning: assert property (
        s_rx_done ##0 (rx_dlc != ctrl_r[rx_sel_w][3:0]) |=>
        status_r[$past(rx_sel_w)][ST_LENGTH_WARNING_FLAG]
        && ctrl_r[$past(rx_sel_w)][3:0] == $past(rx_dlc))
        else $error("length warning not raised");
    a_tx_done_off: assert property (
        s_tx_done |=> status_r[$past(tx_obj_r)][ST_TRANSMIT_DONE_FLAG]
        && !en_r[$past(tx_obj_r)] ##1 !tx_busy_r || tx_start_stb)
        else $error("transmit done did not disable object");
    a_tx_lowest: assert property (
        tx_any_w |-> armed_w[tx_sel_w]
        && (armed_w & ((15'h0001 << tx_sel_w) - 15'h0001)) == '0)
        else $error("transmit pick not lowest");
    a_rx_done_off: assert property (
        s_rx_done ##0 !rx_rtr |=> status_r[$past(rx_sel_w)][ST_RECEIVE_DONE_FLAG]
        && !en_r[$past(rx_sel_w)])
        else $error("receive done did not disable object");
    a_rx_lowest: assert property (
        rx_any_w |-> rx_cand_w[rx_sel_w]
        && (rx_cand_w & ((15'h0001 << rx_sel_w) - 15'h0001)) == '0)
        else $error("receive pick not lowest");
    a_bit_error: assert property (
        sample_stb && err_tx_w && !tx_bit && rx_bit && !in_error_ack
        |=> status_r[$past(tx_obj_r)][ST_BIT_ERROR_FLAG])
        else $error("bit error missed");
    a_err_keeps_en: assert property (
        (|err_set_w) && !tx_done_w && !rx_done_w && !wr_ctrl
        |=> en_r == $past(en_r))
        else $error("error flag changed enable");
    a_stuff_run: assert property (
        stuff_error_flag_ev |-> run_r == 3'h5 ##1 status_r[$past(cur_obj_w)][ST_STUFF_ERROR_FLAG])
        else $error("stuff error at wrong run length");
    a_status_clear: assert property (
        wr_stat && obj_ok_w && !wdata_r[ST_TRANSMIT_DONE_FLAG] && !tx_done_w
        |=> !status_r[$past(page_r)][ST_TRANSMIT_DONE_FLAG])
        else $error("status write of zero did not clear");
    a_cfg_arms: assert property (
        wr_ctrl && obj_ok_w |=> en_r[$past(page_r)]
        && !done_r[$past(page_r)])
        else $error("config write did not arm object");
    a_dlc_capped: assert property (
        tx_req |-> tx_dlc <= 4'h8)
        else $error("offered length above eight");
endmodule // cmost_core

// ---- tb/cmost_nodes.sv ----
// Bus-side node model: sampled bit levels and frame events
`timescale 1ns/1ps
module cmost_nodes (
    input wire logic aclk,
    output logic [12:0] lv,
    output logic sample_stb,
    output logic [3:0] evs
);
    initial begin
        lv = 13'h1000;
        sample_stb = 1'b0;
        evs = 4'h0;
    end
    // Level held long enough to pass the input synchroniser
    task automatic bit_(input logic [12:0] v);
        @(posedge aclk);
        lv <= v;
        repeat (5) @(posedge aclk);
        sample_stb <= 1'b1;
        @(posedge aclk);
        sample_stb <= 1'b0;
    endtask
    // Event pulse: 0 start, 1 end of frame, 2 abort, 3 receive done
    task automatic ev(input int k);
        @(posedge aclk);
        evs <= 4'h1 << k;
        @(posedge aclk);
        evs <= 4'h0;
    endtask
endmodule // cmost_nodes

// ---- tb/can_message_object_status_tag_bench.sv ----
// Testbench of the message object status and tag block
`timescale 1ns/1ps
module can_message_object_status_tag_bench;
    import cmost_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, can_rx, sample_stb;
    logic frame_start_stb, tx_active, tx_bit, in_arbitration, in_error_ack;
    logic stuff_check_en, bit_is_stuff, crc_calc_en, crc_recv_en;
    logic crc_check_stb, fixed_form_en, ack_slot, tx_start_stb, tx_abort_stb;
    logic tx_eof_stb, rx_eof6_stb, rx_ide, rx_rtr, rx_rb0, rx_rb1, tx_req;
    logic tx_ide, tx_rtr, tx_rb0, tx_rb1;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rs, tg;
    logic [3:0] s_axi_wstrb, rx_dlc, tx_dlc, evs;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [OBJ_COUNT-1:0] rx_hit_vec;
    logic [28:0] rx_id, tx_id;
    logic [IDX_W-1:0] tx_obj_idx;
    logic [12:0] lv;
    logic [33:0] q[$];
    int num_errors, cmp_count;
    assign {can_rx, tx_active, tx_bit, in_arbitration, in_error_ack,
        stuff_check_en, bit_is_stuff, crc_calc_en, crc_recv_en,
        crc_check_stb, fixed_form_en, ack_slot, frame_start_stb} = lv;
    assign {rx_eof6_stb, tx_abort_stb, tx_eof_stb, tx_start_stb} = evs;
    cmost_core DUT (.*);
    cmost_nodes nodes (.aclk(aclk), .lv(lv), .sample_stb(sample_stb),
        .evs(evs));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [33:0] s, e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic wr(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
        @(posedge aclk);
        q.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e,
        input logic [1:0] r = 2'h0);
        @(posedge aclk);
        q.push_back({r, 16'h0, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // Result watcher: oldest note against each answer
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) chk("bresp", {s_axi_bresp, 32'h0},
            q.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp,
            s_axi_rdata}, q.pop_front());
    end
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, rx_ide, rx_rtr, rx_rb0, rx_rb1} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {rx_dlc, rx_hit_vec, rx_id} = '0;
        aresetn = 1'b0;
        rs = 32'd51582;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd(8'(4 * i), 16'h0);
        rd(8'h24, 16'h0, RESP_SLVERR);
        wr(OFF_ENABLE, 8'hFF, RESP_SLVERR);
        wr(OFF_PAGE, 8'hF0);
        wr(OFF_CTRL, 8'h48);
        rd(OFF_CTRL, 16'h0);
        rs = xs(rs);
        wr(OFF_PAGE, 8'h20);
        wr(OFF_TAG1, rs[7:0]);
        wr(OFF_TAG2, {rs[10:8], 5'h0});
        wr(OFF_TAG4, {7'h0, rs[11]});
        wr(OFF_CTRL, 8'h4B);
        wr(OFF_PAGE, 8'h10);
        wr(OFF_CTRL, 8'h48);
        rd(OFF_ENABLE, 16'h0006);
        chk("tx_idx", tx_obj_idx, 1);
        nodes.ev(0);
        nodes.ev(1);
        rd(OFF_STATUS, 16'h0040);
        rd(OFF_ENABLE, 16'h0004);
        chk("tx_idx2", {tx_req, tx_obj_idx}, 5'h12);
        chk("tx_dlc", {tx_ide, tx_dlc}, 5'h08);
        chk("tx_id", {tx_id, tx_rtr, tx_rb1, tx_rb0},
            {18'h0, rs[7:0], rs[10:8], 2'h0, rs[11]});
        rs = xs(rs);
        for (int i = 4; i < 6; i++) begin
            wr(OFF_PAGE, 8'(i << 4));
            wr(OFF_CTRL, 8'h82);
        end
        rx_id <= rs[28:0];
        tg[31:3] = rs[28:0];
        rs = xs(rs);
        {rx_ide, rx_rtr, rx_rb1, rx_rb0, rx_dlc} <= {1'b1, rs[6:0]};
        tg[2:0] = rs[6:4];
        rx_hit_vec <= 15'h0030;
        nodes.ev(3);
        wr(OFF_PAGE, 8'h40);
        rd(OFF_STATUS, {8'h0, rs[3:0] != 4'h2, 7'h20});
        rd(OFF_CTRL, {8'h0, 4'h9, rs[3:0]});
        for (int i = 0; i < 4; i++) begin
            rd(OFF_TAG1 + 8'(4 * i), 16'(tg[31-8*i -: 8]));
        end
        rd(OFF_ENABLE, 16'h0024);
        s_axi_wstrb <= {rs[9:7], 1'b0};
        wr(OFF_STATUS, 8'h00);
        s_axi_wstrb <= 4'hF;
        rd(OFF_STATUS, {8'h0, rs[3:0] != 4'h2, 7'h20});
        wr(OFF_STATUS, 8'h7F);
        rd(OFF_STATUS, 16'h0020);
        wr(OFF_CTRL, 8'h82);
        rd(OFF_ENABLE, 16'h0034);
        rx_hit_vec <= 15'h0010;
        repeat (6) nodes.bit_(13'h0080);
        nodes.bit_(13'h0004);
        nodes.bit_(13'h1000);
        nodes.bit_(13'h1001);
        nodes.bit_(13'h1020);
        nodes.bit_(13'h1060);
        nodes.bit_(13'h0010);
        nodes.bit_(13'h0008);
        nodes.bit_(13'h1000);
        rd(OFF_STATUS, 16'h002E);
        rd(OFF_ENABLE, 16'h0034);
        rx_hit_vec <= 15'h0;
        nodes.ev(0);
        nodes.bit_(13'h0E00);
        nodes.bit_(13'h0D00);
        wr(OFF_PAGE, 8'h20);
        rd(OFF_STATUS, 16'h0000);
        nodes.bit_(13'h0C00);
        nodes.bit_(13'h1800);
        nodes.bit_(13'h1C02);
        nodes.bit_(13'h1000);
        nodes.ev(2);
        rd(OFF_STATUS, 16'h0011);
        rd(OFF_ENABLE, 16'h0034);
        wrap_up();
    end
endmodule // can_message_object_status_tag_bench
